// file: hdl/slc_pkg.sv
// shared constants, carriers, tables and saturating arithmetic for the speech codec core
package slc_pkg;
	localparam int SUB_LEN = 40;
	localparam int HIST_LEN = 120;
	localparam int FRAME_LEN = 160;
	localparam int SUBS_PER_FRAME = 4;
	localparam int LAG_MIN = 40;
	localparam int LAG_MAX = 120;
	localparam int RPE_LEN = 13;
	localparam int GRID_STEP = 3;
	localparam int GRID_CNT = 4;
	localparam int WT_PAD = 5;
	localparam int NTAPS = 11;
	localparam int SCAL_MAX = 6;
	localparam int POWER_SHIFT = 3;
	localparam int EXP_SHIFT = 3;
	localparam int EXP_THRESH = 15;
	localparam int NORM_SHIFT = 6;
	localparam int QUANT_SHIFT = 12;
	localparam int GAIN_LAST = 3;
	localparam int WEIGHT_SHIFT = 13;
	localparam int ENERGY_SHIFT = 2;
	localparam int TRUNC_BITS = 3;
	localparam int REG0_END = 12;
	localparam int REG1_END = 26;
	localparam int REG2_END = 39;
	localparam logic signed [31:0] WEIGHT_RND = 32'sh00001000;
	localparam logic signed [15:0] QUANT_OFS = 16'sh0004;
	localparam logic signed [15:0] DEQ_OFS = 16'sh0007;
	localparam logic signed [15:0] DEEMPH_COEF = 16'sh6E14;
	localparam logic [6:0] LAG_RESET = 7'h28;

	typedef struct packed {
		logic [6:0] lag;
		logic [1:0] gain;
		logic [1:0] grid;
		logic [5:0] max_code;
		logic [3*RPE_LEN-1:0] codes;
	} slc_par_s;
	typedef logic [GRID_CNT-1:0][7:0][15:0] slc_refl_t;

	function automatic logic signed [15:0] sat16(input logic signed [31:0] v);
		if (v > 32'sh00007FFF) return 16'sh7FFF;
		if (v < -32'sh00008000) return 16'sh8000;
		return v[15:0];
	endfunction : sat16
	function automatic logic signed [15:0] add16(input logic signed [15:0] a, input logic signed [15:0] b);
		return sat16(32'(a) + 32'(b));
	endfunction : add16
	function automatic logic signed [15:0] sub16(input logic signed [15:0] a, input logic signed [15:0] b);
		return sat16(32'(a) - 32'(b));
	endfunction : sub16
	function automatic logic signed [15:0] abs16(input logic signed [15:0] a);
		return (a == 16'sh8000) ? 16'sh7FFF : ((a < 0) ? -a : a);
	endfunction : abs16
	// only -1 * -1 overflows the q15 product
	function automatic logic signed [15:0] mult(input logic signed [15:0] a, input logic signed [15:0] b);
		logic signed [31:0] p;
		p = 32'(a) * 32'(b);
		if (a == 16'sh8000 && b == 16'sh8000) return 16'sh7FFF;
		return p[30:15];
	endfunction : mult
	function automatic logic signed [15:0] mult_r(input logic signed [15:0] a, input logic signed [15:0] b);
		logic signed [31:0] p;
		p = 32'(a) * 32'(b) + 32'sh00004000;
		if (a == 16'sh8000 && b == 16'sh8000) return 16'sh7FFF;
		return p[30:15];
	endfunction : mult_r
	function automatic logic signed [31:0] lmult(input logic signed [15:0] a, input logic signed [15:0] b);
		logic signed [31:0] p;
		p = 32'(a) * 32'(b);
		if (a == 16'sh8000 && b == 16'sh8000) return 32'sh7FFFFFFF;
		return p <<< 1;
	endfunction : lmult
	function automatic logic signed [31:0] ladd(input logic signed [31:0] a, input logic signed [31:0] b);
		logic signed [32:0] s;
		s = 33'(a) + 33'(b);
		if (s[32] != s[31]) return s[32] ? 32'sh80000000 : 32'sh7FFFFFFF;
		return s[31:0];
	endfunction : ladd
	function automatic logic [4:0] norm32(input logic [31:0] x);
		logic [4:0] n;
		logic found;
		n = 5'h00;
		found = 1'b0;
		for (int i = 30; i >= 0; i--) begin
			if (!found && x[i] != x[31]) begin
				n = 5'(30 - i);
				found = 1'b1;
			end
		end
		return n;
	endfunction : norm32
	function automatic logic signed [15:0] gain_decision_levels(input logic [1:0] i);
		case (i)
			2'h0: return 16'sh199A;
			2'h1: return 16'sh4000;
			2'h2: return 16'sh6666;
			default: return 16'sh7FFF;
		endcase
	endfunction : gain_decision_levels
	function automatic logic signed [15:0] gain_quant_levels(input logic [1:0] i);
		case (i)
			2'h0: return 16'sh0CCD;
			2'h1: return 16'sh2CCD;
			2'h2: return 16'sh5333;
			default: return 16'sh7FFF;
		endcase
	endfunction : gain_quant_levels
	function automatic logic signed [15:0] inverse_mantissa_table(input logic [2:0] i);
		case (i)
			3'h0: return 16'sh71C8;
			3'h1: return 16'sh6667;
			3'h2: return 16'sh5D18;
			3'h3: return 16'sh5556;
			3'h4: return 16'sh4EC5;
			3'h5: return 16'sh4925;
			3'h6: return 16'sh4444;
			default: return 16'sh4000;
		endcase
	endfunction : inverse_mantissa_table
	function automatic logic signed [15:0] fac(input logic [2:0] i);
		return 16'sh47FF + 16'(16'sh0800 * i);
	endfunction : fac
	function automatic logic signed [15:0] hcoef(input int i);
		case (i)
			0, 10: return -16'sh0086;
			1, 9: return -16'sh0176;
			3, 7: return 16'sh0806;
			4, 6: return 16'sh166D;
			5: return 16'sh2000;
			default: return 16'sh0000;
		endcase
	endfunction : hcoef
	function automatic logic [1:0] region_of(input logic [7:0] k);
		if (k <= 8'(REG0_END)) return 2'h0;
		if (k <= 8'(REG1_END)) return 2'h1;
		if (k <= 8'(REG2_END)) return 2'h2;
		return 2'h3;
	endfunction : region_of
endpackage : slc_pkg

// file: hdl/slc_synth_post.sv
// short-term lattice synthesis, de-emphasis, upscaling and truncation, one sample per cycle
`timescale 1ns/1ps
module slc_synth_post import slc_pkg::*; (
	input wire logic i_mclk, // system clock
	input wire logic i_sys_rst, // sync reset, active high
	input wire logic i_valid, // frame sample strobe
	input wire logic [7:0] i_idx, // sample index in frame
	input wire logic signed [15:0] i_sample, // long-term synthesis output
	input wire slc_refl_t i_refl, // reflection sets per region
	output logic o_valid, // output sample strobe
	output logic signed [15:0] o_sample // upscaled truncated sample
);
	logic signed [15:0] v_r [0:8];
	logic signed [15:0] v_nxt [0:8];
	logic signed [15:0] deemph_r;
	logic signed [15:0] sri;
	logic signed [15:0] msr;
	logic signed [15:0] rc;
	logic [1:0] reg_sel;

	always_comb begin
		reg_sel = region_of(i_idx); // [RULE25]
		sri = i_sample;
		for (int j = 0; j <= 8; j++) v_nxt[j] = v_r[j];
		for (int i = 1; i <= 8; i++) begin
			rc = signed'(i_refl[reg_sel][8-i]);
			sri = sub16(sri, mult_r(rc, v_r[8-i])); // [RULE19]
			v_nxt[9-i] = add16(v_r[8-i], mult_r(rc, sri)); // [RULE19]
		end
		v_nxt[0] = sri; // [RULE19]
		msr = add16(sri, mult_r(deemph_r, DEEMPH_COEF)); // [RULE20]
	end

	always_ff @(posedge i_mclk) begin
		if (i_sys_rst) begin
			for (int j = 0; j <= 8; j++) v_r[j] <= 16'sh0000;
			deemph_r <= 16'sh0000;
		end else if (i_valid) begin
			for (int j = 0; j <= 8; j++) v_r[j] <= v_nxt[j];
			deemph_r <= msr; // [RULE20]
		end
	end

	always_ff @(posedge i_mclk) begin
		if (i_sys_rst) begin
			o_valid <= 1'b0;
			o_sample <= 16'sh0000;
		end else begin
			o_valid <= i_valid;
			if (i_valid) o_sample <= add16(msr, msr) & ~16'((1 << TRUNC_BITS) - 1); // [RULE21]
		end
	end
endmodule : slc_synth_post

// file: hdl/slc_codec_core.sv
// ltp/rpe codec core: encoder sub-segment datapath and decoder with frame post-processing
// Functional notes
// [RULE1] scale residual by peak normalisation into work_array
// [RULE2] pick lag of max correlation, rescale peak
// [RULE3] reload delayed history >>3, saturating energy sum
// [RULE4] gain code: first index meeting decision level
// [RULE5] estimate is gain times history; residual difference
// [RULE6] weighting input pads five zeros each side
// [RULE7] subsamples every third weighted sample from grid
// [RULE8] block max is largest subsample magnitude
// [RULE9] derive block shift and fraction from code
// [RULE10] quantise subsamples to 3-bit non-negative codes
// [RULE11] dequantise codes with mantissa and shift
// [RULE12] place dequantised samples on grid, zeros elsewhere
// [RULE13] encoder history shifts by 40, new sums
// [RULE14] decoder per sub-segment, post-processing per frame
// [RULE15] received lag accepted only within 40..120
// [RULE16] decoder residual plus gained delayed history
// [RULE17] decoder history shifts down by 40
// [RULE18] sub-segments land at frame offsets 0/40/80/120
// [RULE19] eight-stage lattice synthesis with nine-element state
// [RULE20] de-emphasis recursion with 28180, kept across frames
// [RULE21] double with saturation, clear three low bits
// [RULE22] gain decision and quantisation level tables
// [RULE23] inverse and direct mantissa tables
// [RULE24] eleven weighting coefficients
// [RULE25] synthesis coefficient set chosen per region
// [RULE26] saturating 16-bit add/sub, rounded multiplies
// [RULE27] rounded convolution; grid of greatest energy
// [RULE28] lag search 40..120, first maximum wins
`timescale 1ns/1ps
module slc_codec_core import slc_pkg::*; #(
	parameter int P_LAG_MIN = LAG_MIN, // smallest lag searched/accepted
	parameter int P_LAG_MAX = LAG_MAX // largest lag searched/accepted
) (
	input wire logic i_mclk, // system clock
	input wire logic i_sys_rst, // sync reset, active high
	input wire logic i_res_valid, // short-term residual sample strobe
	input wire logic signed [15:0] i_res_sample, // residual sample
	output logic o_res_ready, // encoder takes residual samples
	output logic o_max_req, // block max waiting for its code
	output logic [15:0] o_block_max, // block maximum magnitude
	input wire logic i_max_code_valid, // block max code strobe
	input wire logic [5:0] i_max_code, // coded block maximum
	output logic o_enc_valid, // coded parameters strobe
	output slc_par_s o_enc_par, // coded sub-segment parameters
	input wire logic i_dec_valid, // received parameters strobe
	input wire slc_par_s i_dec_par, // received sub-segment parameters
	input wire slc_refl_t i_dec_refl, // decoded reflection sets, with last sub-segment
	output logic o_dec_ready, // decoder takes parameters
	output logic o_out_valid, // decoded sample strobe
	output logic signed [15:0] o_out_sample // decoded output sample
);
	initial begin
		if (P_LAG_MIN < SUB_LEN || P_LAG_MAX > HIST_LEN || P_LAG_MIN > P_LAG_MAX)
			$error("slc_codec_core: lag range outside history");
	end

	typedef enum logic [8:0] {
		E_LOAD = 9'h001, E_SCALE = 9'h002, E_XCORR = 9'h004, E_POWER = 9'h008, E_GAIN = 9'h010,
		E_FILT = 9'h020, E_RPE = 9'h040, E_WMAX = 9'h080, E_QUANT = 9'h100
	} slc_enc_e;
	typedef enum logic [1:0] {D_IN = 2'h1, D_OUT = 2'h2} slc_dec_e;

	// block shift and fraction packed as {shift, fraction}
	function automatic logic [5:0] exp_mant(input logic [5:0] code);
		logic [2:0] ex;
		ex = (code > 6'(EXP_THRESH)) ? 3'((code >> EXP_SHIFT) - 6'h01) : 3'h0; // [RULE9]
		return {ex, 3'(code - 6'({ex, 3'h0}))}; // [RULE9]
	endfunction : exp_mant

	function automatic logic signed [15:0] dequant(input logic [2:0] c, input logic [5:0] em);
		logic signed [15:0] t;
		logic signed [15:0] rnd;
		logic [2:0] sh;
		sh = 3'(NORM_SHIFT) - em[5:3];
		rnd = (sh == 3'h0) ? 16'sh0000 : 16'(16'sh0001 << (sh - 3'h1));
		t = sub16(16'({13'h0000, c}) <<< 1, DEQ_OFS) <<< QUANT_SHIFT; // [RULE11]
		t = mult_r(fac(em[2:0]), t); // [RULE11] [RULE23]
		return add16(t, rnd) >>> sh; // [RULE11]
	endfunction : dequant

	slc_enc_e enc_st_r;
	slc_dec_e dec_st_r;
	logic signed [15:0] d_r [0:SUB_LEN-1];
	logic signed [15:0] wt_r [0:SUB_LEN-1];
	logic signed [15:0] dp_r [0:HIST_LEN-1];
	logic signed [15:0] dpp_r [0:SUB_LEN-1];
	logic signed [15:0] e_r [0:SUB_LEN-1];
	logic signed [15:0] xm_r [0:RPE_LEN-1];
	logic [5:0] k_r;
	logic [15:0] dmax_r;
	logic [6:0] lag_r;
	logic [6:0] best_lag_r;
	logic signed [31:0] lmax_r;
	logic signed [31:0] power_r;
	logic [1:0] gain_r;
	logic [1:0] grid_r;
	logic [5:0] maxc_r;

	logic [4:0] nrm;
	logic [2:0] scal;
	logic signed [31:0] corr;
	logic signed [31:0] power;
	logic signed [15:0] hw;
	logic [1:0] gain;
	logic [4:0] pn;
	logic signed [15:0] rr;
	logic signed [15:0] ss;
	logic signed [31:0] rl;
	logic signed [31:0] sl;
	logic signed [15:0] wpad [0:SUB_LEN+2*WT_PAD-1];
	logic signed [15:0] xw [0:SUB_LEN-1];
	logic signed [31:0] acc;
	logic signed [31:0] en;
	logic signed [31:0] best_en;
	logic [1:0] grid;
	logic [15:0] bmax;
	logic [5:0] em;
	logic [2:0] qsh;
	logic signed [15:0] qt;
	logic [3*RPE_LEN-1:0] codes;
	logic signed [15:0] ep [0:SUB_LEN-1];

	// residual scaling
	always_comb begin
		nrm = norm32({dmax_r, 16'h0000});
		scal = (dmax_r == 16'h0000 || nrm > 5'(SCAL_MAX)) ? 3'h0 : 3'(5'(SCAL_MAX) - nrm); // [RULE1]
	end

	// correlation for the lag under test; one lag per cycle
	always_comb begin
		corr = 32'sh00000000;
		for (int k = 0; k < SUB_LEN; k++)
			corr = corr + lmult(wt_r[k], dp_r[HIST_LEN + k - int'(lag_r)]); // [RULE2]
	end

	always_comb begin
		power = 32'sh00000000;
		for (int k = 0; k < SUB_LEN; k++) begin
			hw = dp_r[HIST_LEN + k - int'(best_lag_r)] >>> POWER_SHIFT; // [RULE3]
			power = ladd(lmult(hw, hw), power); // [RULE3] [RULE26]
		end
	end

	always_comb begin
		pn = norm32(power_r);
		rl = lmax_r <<< pn;
		sl = power_r <<< pn;
		rr = rl[31:16];
		ss = sl[31:16];
		gain = 2'(GAIN_LAST);
		if (lmax_r <= 0) gain = 2'h0;
		else if (lmax_r < power_r) begin
			for (int b = GAIN_LAST - 1; b >= 0; b--)
				if (rr <= mult(ss, gain_decision_levels(2'(b)))) gain = 2'(b); // [RULE4] [RULE22]
		end
	end

	// weighting filter, grid choice and block maximum in one pass
	always_comb begin
		for (int j = 0; j < SUB_LEN + 2 * WT_PAD; j++)
			wpad[j] = (j >= WT_PAD && j < SUB_LEN + WT_PAD) ? e_r[j-WT_PAD] : 16'sh0000; // [RULE6]
		for (int k = 0; k < SUB_LEN; k++) begin
			acc = WEIGHT_RND;
			for (int i = 0; i < NTAPS; i++)
				acc = acc + 32'(hcoef(i)) * 32'(wpad[k+i]); // [RULE24] [RULE27]
			xw[k] = sat16(acc >>> WEIGHT_SHIFT); // [RULE27]
		end
		best_en = 32'sh00000000;
		grid = 2'h0;
		for (int m = 0; m < GRID_CNT; m++) begin
			en = 32'sh00000000;
			for (int i = 0; i < RPE_LEN; i++)
				en = ladd(en, lmult(xw[m+GRID_STEP*i] >>> ENERGY_SHIFT, xw[m+GRID_STEP*i] >>> ENERGY_SHIFT));
			if (m == 0 || en > best_en) begin // [RULE27]
				best_en = en;
				grid = 2'(m);
			end
		end
		bmax = 16'h0000;
		for (int i = 0; i < RPE_LEN; i++)
			if (abs16(xw[int'(grid)+GRID_STEP*i]) > signed'(bmax)) bmax = abs16(xw[int'(grid)+GRID_STEP*i]); // [RULE8]
	end

	// quantise, dequantise and rebuild the long-term residual
	always_comb begin
		em = exp_mant(maxc_r);
		qsh = 3'(NORM_SHIFT) - em[5:3];
		for (int k = 0; k < SUB_LEN; k++) ep[k] = 16'sh0000; // [RULE12]
		codes = '0;
		for (int i = 0; i < RPE_LEN; i++) begin
			qt = mult(xm_r[i] <<< qsh, inverse_mantissa_table(em[2:0])); // [RULE10] [RULE23]
			codes[3*i +: 3] = 3'(add16(qt >>> QUANT_SHIFT, QUANT_OFS)); // [RULE10]
			ep[int'(grid_r) + GRID_STEP*i] = dequant(codes[3*i +: 3], em); // [RULE12]
		end
	end

	always_ff @(posedge i_mclk) begin
		if (i_sys_rst) begin
			enc_st_r <= E_LOAD;
			k_r <= 6'h00;
			dmax_r <= 16'h0000;
			lag_r <= 7'(P_LAG_MIN);
			best_lag_r <= 7'(P_LAG_MIN);
			lmax_r <= 32'sh00000000;
			power_r <= 32'sh00000000;
			gain_r <= 2'h0;
			grid_r <= 2'h0;
			maxc_r <= 6'h00;
		end else begin
			case (enc_st_r)
				E_LOAD: if (i_res_valid) begin
					if (abs16(i_res_sample) > signed'(dmax_r)) dmax_r <= abs16(i_res_sample); // [RULE1]
					k_r <= k_r + 6'h01;
					if (k_r == 6'(SUB_LEN - 1)) enc_st_r <= E_SCALE;
				end
				E_SCALE: begin
					lag_r <= 7'(P_LAG_MIN);
					enc_st_r <= E_XCORR;
				end
				E_XCORR: begin
					if (lag_r == 7'(P_LAG_MIN) || corr > lmax_r) begin // [RULE28]
						lmax_r <= corr;
						best_lag_r <= lag_r;
					end
					lag_r <= lag_r + 7'h01;
					if (lag_r == 7'(P_LAG_MAX)) enc_st_r <= E_POWER; // [RULE28]
				end
				E_POWER: begin
					lmax_r <= lmax_r >>> (3'(SCAL_MAX) - scal); // [RULE2]
					power_r <= power;
					enc_st_r <= E_GAIN;
				end
				E_GAIN: begin
					gain_r <= gain;
					enc_st_r <= E_FILT;
				end
				E_FILT: enc_st_r <= E_RPE;
				E_RPE: begin
					grid_r <= grid;
					enc_st_r <= E_WMAX;
				end
				E_WMAX: if (i_max_code_valid) begin
					// the code pin may move on once taken, quantise from a copy
					maxc_r <= i_max_code;
					enc_st_r <= E_QUANT;
				end
				E_QUANT: begin
					k_r <= 6'h00;
					dmax_r <= 16'h0000;
					enc_st_r <= E_LOAD;
				end
				default: enc_st_r <= E_LOAD;
			endcase
		end
	end

	// sample and working arrays
	always_ff @(posedge i_mclk) begin
		if (i_sys_rst) begin
			for (int k = 0; k < SUB_LEN; k++) begin
				d_r[k] <= 16'sh0000;
				wt_r[k] <= 16'sh0000;
				dpp_r[k] <= 16'sh0000;
				e_r[k] <= 16'sh0000;
			end
			for (int i = 0; i < RPE_LEN; i++) xm_r[i] <= 16'sh0000;
		end else begin
			if (enc_st_r == E_LOAD && i_res_valid) d_r[k_r] <= i_res_sample;
			if (enc_st_r == E_SCALE)
				for (int k = 0; k < SUB_LEN; k++) wt_r[k] <= d_r[k] >>> scal; // [RULE1]
			if (enc_st_r == E_FILT)
				for (int k = 0; k < SUB_LEN; k++) begin
					dpp_r[k] <= mult_r(gain_quant_levels(gain_r), dp_r[HIST_LEN + k - int'(best_lag_r)]); // [RULE5]
					e_r[k] <= sub16(d_r[k], mult_r(gain_quant_levels(gain_r), dp_r[HIST_LEN + k - int'(best_lag_r)])); // [RULE5]
				end
			if (enc_st_r == E_RPE)
				for (int i = 0; i < RPE_LEN; i++) xm_r[i] <= xw[int'(grid)+GRID_STEP*i]; // [RULE7]
		end
	end

	always_ff @(posedge i_mclk) begin
		if (i_sys_rst) begin
			for (int k = 0; k < HIST_LEN; k++) dp_r[k] <= 16'sh0000; // [RULE13]
		end else if (enc_st_r == E_QUANT) begin
			for (int k = 0; k < HIST_LEN - SUB_LEN; k++) dp_r[k] <= dp_r[k+SUB_LEN]; // [RULE13]
			for (int k = 0; k < SUB_LEN; k++) dp_r[HIST_LEN-SUB_LEN+k] <= add16(ep[k], dpp_r[k]); // [RULE13]
		end
	end

	always_ff @(posedge i_mclk) begin
		if (i_sys_rst) begin
			o_res_ready <= 1'b0;
			o_max_req <= 1'b0;
			o_block_max <= 16'h0000;
			o_enc_valid <= 1'b0;
			o_enc_par <= '0;
		end else begin
			o_res_ready <= (enc_st_r == E_LOAD && !(i_res_valid && k_r == 6'(SUB_LEN - 1))) || enc_st_r == E_QUANT;
			o_enc_valid <= enc_st_r == E_QUANT;
			if (enc_st_r == E_RPE) begin
				o_max_req <= 1'b1;
				o_block_max <= bmax; // [RULE8]
			end else if (enc_st_r == E_WMAX && i_max_code_valid) o_max_req <= 1'b0;
			if (enc_st_r == E_QUANT) begin
				o_enc_par.lag <= best_lag_r;
				o_enc_par.gain <= gain_r;
				o_enc_par.grid <= grid_r;
				o_enc_par.max_code <= maxc_r;
				o_enc_par.codes <= codes;
			end
		end
	end

	// decoder: one sub-segment per accepted parameter set
	logic signed [15:0] drp_r [0:HIST_LEN-1];
	logic signed [15:0] frame_r [0:FRAME_LEN-1];
	logic [6:0] last_lag_r;
	logic [1:0] sub_r;
	logic [7:0] out_idx_r;
	slc_refl_t refl_r;
	logic [6:0] nr;
	logic [5:0] dem;
	logic signed [15:0] erp [0:SUB_LEN-1];
	logic signed [15:0] drp [0:SUB_LEN-1];

	always_comb begin
		nr = (i_dec_par.lag < 7'(P_LAG_MIN) || i_dec_par.lag > 7'(P_LAG_MAX)) ? last_lag_r : i_dec_par.lag; // [RULE15]
		dem = exp_mant(i_dec_par.max_code); // [RULE14]
		for (int k = 0; k < SUB_LEN; k++) erp[k] = 16'sh0000;
		for (int i = 0; i < RPE_LEN; i++)
			erp[int'(i_dec_par.grid) + GRID_STEP*i] = dequant(i_dec_par.codes[3*i +: 3], dem); // [RULE14]
		// lag is never below one sub-segment, so only history is read
		for (int k = 0; k < SUB_LEN; k++)
			drp[k] = add16(erp[k], mult_r(gain_quant_levels(i_dec_par.gain), drp_r[HIST_LEN + k - int'(nr)])); // [RULE16]
	end

	always_ff @(posedge i_mclk) begin
		if (i_sys_rst) begin
			dec_st_r <= D_IN;
			last_lag_r <= LAG_RESET; // [RULE15]
			sub_r <= 2'h0;
			out_idx_r <= 8'h00;
			refl_r <= '0;
			o_dec_ready <= 1'b0;
			for (int k = 0; k < HIST_LEN; k++) drp_r[k] <= 16'sh0000; // [RULE17]
			for (int k = 0; k < FRAME_LEN; k++) frame_r[k] <= 16'sh0000;
		end else begin
			case (dec_st_r)
				D_IN: begin
					o_dec_ready <= !(i_dec_valid && sub_r == 2'(SUBS_PER_FRAME - 1));
					if (i_dec_valid) begin
						last_lag_r <= nr; // [RULE15]
						for (int k = 0; k < HIST_LEN - SUB_LEN; k++) drp_r[k] <= drp_r[k+SUB_LEN]; // [RULE17]
						for (int k = 0; k < SUB_LEN; k++) begin
							drp_r[HIST_LEN-SUB_LEN+k] <= drp[k]; // [RULE17]
							frame_r[int'(sub_r)*SUB_LEN + k] <= drp[k]; // [RULE18]
						end
						sub_r <= sub_r + 2'h1;
						if (sub_r == 2'(SUBS_PER_FRAME - 1)) begin
							refl_r <= i_dec_refl;
							out_idx_r <= 8'h00;
							dec_st_r <= D_OUT; // [RULE14]
						end
					end
				end
				D_OUT: begin
					out_idx_r <= out_idx_r + 8'h01;
					if (out_idx_r == 8'(FRAME_LEN - 1)) begin
						out_idx_r <= 8'h00;
						dec_st_r <= D_IN;
					end
				end
				default: dec_st_r <= D_IN;
			endcase
		end
	end

	slc_synth_post u_post (
		.i_mclk(i_mclk),
		.i_sys_rst(i_sys_rst),
		.i_valid(dec_st_r == D_OUT),
		.i_idx(out_idx_r),
		.i_sample(frame_r[out_idx_r]),
		.i_refl(refl_r),
		.o_valid(o_out_valid),
		.o_sample(o_out_sample)
	);
endmodule : slc_codec_core

// file: dv/slc_codec_core_assertions.sv
// port-level checks on the codec core
`timescale 1ns/1ps
module slc_codec_core_assertions import slc_pkg::*; #(
	parameter int P_LAG_MIN = LAG_MIN, // low lag
	parameter int P_LAG_MAX = LAG_MAX // high lag
) (
	input wire logic i_mclk, // clock
	input wire logic i_sys_rst, // reset
	input wire logic o_res_ready, // enc ready
	input wire logic o_max_req, // max pending
	input wire logic [15:0] o_block_max, // block max
	input wire logic i_max_code_valid, // code strobe
	input wire logic [5:0] i_max_code, // code
	input wire logic o_enc_valid, // par strobe
	input wire slc_par_s o_enc_par, // params
	input wire logic o_dec_ready, // dec ready
	input wire logic o_out_valid, // out strobe
	input wire logic signed [15:0] o_out_sample // out sample
);
	logic [7:0] out_cnt_r;
	always_ff @(posedge i_mclk) begin
		if (i_sys_rst || !o_out_valid) out_cnt_r <= 8'h00;
		else out_cnt_r <= out_cnt_r + 8'h01;
	end
	default clocking cb @(posedge i_mclk); endclocking
	default disable iff (i_sys_rst);
	property p_rdy; $fell(i_sys_rst) |=> o_res_ready && o_dec_ready; endproperty
	a_rdy: assert property (p_rdy) else $error("ready late");
	property p_trunc; o_out_valid |-> o_out_sample[2:0] == 3'h0; endproperty
	a_trunc: assert property (p_trunc) else $error("low bits set");
	property p_burst; $fell(o_out_valid) |-> out_cnt_r == 8'hA0; endproperty
	a_burst: assert property (p_burst) else $error("frame length");
	property p_busy; o_out_valid |-> !o_dec_ready; endproperty
	a_busy: assert property (p_busy) else $error("ready in output");
	property p_hold; o_max_req && !i_max_code_valid |=> o_max_req && $stable(o_block_max); endproperty
	a_hold: assert property (p_hold) else $error("max dropped");
	property p_code; o_max_req && i_max_code_valid |=> !o_max_req ##1
		(o_enc_valid && o_enc_par.max_code == $past(i_max_code, 2)); endproperty
	a_code: assert property (p_code) else $error("code not passed");
	property p_lag; o_enc_valid |-> o_enc_par.lag >= P_LAG_MIN && o_enc_par.lag <= P_LAG_MAX; endproperty
	a_lag: assert property (p_lag) else $error("lag range");
	property p_next; o_enc_valid |-> o_res_ready && !o_max_req; endproperty
	a_next: assert property (p_next) else $error("not reloading");
	c_enc: cover property (o_enc_valid);
	c_frame: cover property ($fell(o_out_valid));
	c_take: cover property (o_max_req && i_max_code_valid);
endmodule : slc_codec_core_assertions

// file: dv/slc_partner.sv
// residual source and block-max coder beside the core
`timescale 1ns/1ps
module slc_partner (
	input wire logic i_mclk, // clock
	input wire logic i_go, // start a sub-segment
	input wire logic [15:0] i_val, // sample value
	input wire logic [5:0] i_code, // max code
	input wire logic i_res_ready, // core ready
	input wire logic i_max_req, // core waits
	output logic o_res_valid, // sample strobe
	output logic [15:0] o_res_sample, // sample
	output logic o_max_code_valid, // code strobe
	output logic [5:0] o_max_code // code
);
	initial begin
		o_res_valid = 1'b0;
		o_res_sample = 16'hFFFF;
		o_max_code_valid = 1'b0;
		o_max_code = 6'h3F;
	end
	// idle lines carry inverted data so stale values never pass
	always begin
		@(posedge i_mclk);
		if (i_go && i_res_ready) begin
			@(negedge i_mclk);
			repeat (40) begin
				o_res_valid = 1'b1;
				o_res_sample = i_val;
				@(negedge i_mclk);
			end
			o_res_valid = 1'b0;
			o_res_sample = ~i_val;
			for (int n = 0; n < 300 && i_max_req !== 1'b1; n++) @(negedge i_mclk);
			repeat (3) @(negedge i_mclk);
			o_max_code_valid = 1'b1;
			o_max_code = i_code;
			@(negedge i_mclk);
			o_max_code_valid = 1'b0;
			o_max_code = ~i_code;
		end
	end
endmodule : slc_partner

// file: dv/slc_codec_core_test.sv
// self-checking bench for the codec core
`timescale 1ns/1ps
`define CHK(a, b, m) begin total_checks++; if ((a) !== (b)) begin n_mismatch++; \
	$display("CHECK FAILED %0t %s", $time, m); end end
module slc_codec_core_test;
	import slc_pkg::*;
	logic i_mclk = 0, i_sys_rst = 1, go = 0, rv, mv, o_res_ready, o_max_req, o_enc_valid;
	logic i_dec_valid = 0, o_dec_ready, o_out_valid;
	logic [15:0] rs, o_block_max;
	logic signed [15:0] o_out_sample;
	logic [5:0] mc;
	slc_par_s o_enc_par, i_dec_par = '0;
	slc_refl_t i_dec_refl = '0;
	logic [6:0] lags [4] = '{7'h1E, 7'h79, 7'h28, 7'h00};
	int n_mismatch = 0, total_checks = 0, prv[40], m = 0, eq[160], n;
	always #5 i_mclk = ~i_mclk;
	slc_partner u_slc_partner (.i_mclk(i_mclk), .i_go(go), .i_val(16'h0001), .i_code(6'h07),
		.i_res_ready(o_res_ready), .i_max_req(o_max_req), .o_res_valid(rv), .o_res_sample(rs),
		.o_max_code_valid(mv), .o_max_code(mc));
	slc_codec_core u_slc_codec_core (.i_mclk(i_mclk), .i_sys_rst(i_sys_rst), .i_res_valid(rv),
		.i_res_sample(rs), .o_res_ready(o_res_ready), .o_max_req(o_max_req), .o_block_max(o_block_max),
		.i_max_code_valid(mv), .i_max_code(mc), .o_enc_valid(o_enc_valid), .o_enc_par(o_enc_par),
		.i_dec_valid(i_dec_valid), .i_dec_par(i_dec_par), .i_dec_refl(i_dec_refl),
		.o_dec_ready(o_dec_ready), .o_out_valid(o_out_valid), .o_out_sample(o_out_sample));
	function automatic int sat(int v);
		return v > 32767 ? 32767 : (v < -32768 ? -32768 : v);
	endfunction : sat
	function automatic int mr(int a, int b);
		return (a * b + 16384) >>> 15;
	endfunction : mr
	task conclude;
		$display("checks %0d mismatches %0d", total_checks, n_mismatch);
		if (n_mismatch == 0 && total_checks > 0) $display("bench passed");
		else $display("bench failed");
		$finish;
	endtask : conclude
	task tmo(input bit ok);
		if (!ok) begin
			n_mismatch++;
			conclude();
		end
	endtask : tmo
	task test_reset;
		repeat (5) @(negedge i_mclk);
		`CHK({o_res_ready, o_dec_ready}, 2'b00, "ready in reset")
		i_sys_rst = 0;
		repeat (2) @(negedge i_mclk);
		`CHK({o_res_ready, o_dec_ready}, 2'b11, "ready after reset")
		$display("test_reset done");
	endtask : test_reset
	task test_enc;
		go = 1;
		@(negedge i_mclk);
		go = 0;
		for (n = 0; n < 400 && o_max_req !== 1'b1; n++) @(negedge i_mclk);
		tmo(o_max_req === 1'b1);
		// unit samples: full taps round to 3, edge taps to 2 or 3, energies all zero so grid 0
		`CHK(o_block_max, 16'h0003, "block max")
		for (n = 0; n < 20 && o_enc_valid !== 1'b1; n++) @(negedge i_mclk);
		tmo(o_enc_valid === 1'b1);
		// silent history: first lag, gain 0, grid 0, mid codes
		`CHK(o_enc_par, {7'h28, 2'h0, 2'h0, 6'h07, {13{3'h4}}}, "enc params")
		$display("test_enc done");
	endtask : test_enc
	task test_dec;
		int d, j;
		for (int k = 0; k < 160; k++) begin
			j = k % 40;
			d = (j % 3 == 0 && j <= 36) ? (mr(18431, 4096) + 32) >>> 6 : 0;
			d = sat(d + mr(3277, prv[j]));
			prv[j] = d;
			m = sat(d + mr(m, 28180));
			eq[k] = sat(2 * m) & ~7;
		end
		for (int s = 0; s < 4; s++) begin
			for (n = 0; n < 300 && o_dec_ready !== 1'b1; n++) @(negedge i_mclk);
			tmo(o_dec_ready === 1'b1);
			i_dec_par = '{lag: lags[s], gain: 2'h0, grid: 2'h0, max_code: 6'h00, codes: {13{3'h4}}};
			i_dec_valid = 1;
			@(negedge i_mclk);
		end
		i_dec_valid = 0;
		for (n = 0; n < 10 && o_out_valid !== 1'b1; n++) @(negedge i_mclk);
		tmo(o_out_valid === 1'b1);
		for (int k = 0; k < 160; k++) begin
			`CHK(o_out_sample, 16'(eq[k]), "dec sample")
			@(negedge i_mclk);
		end
		$display("test_dec done");
	endtask : test_dec
	initial begin
		test_reset();
		test_enc();
		test_dec();
		test_dec();
		conclude();
	end
endmodule : slc_codec_core_test
bind slc_codec_core slc_codec_core_assertions #(.P_LAG_MIN(P_LAG_MIN), .P_LAG_MAX(P_LAG_MAX))
	u_slc_codec_core_assertions (.i_mclk(i_mclk), .i_sys_rst(i_sys_rst), .o_res_ready(o_res_ready),
	.o_max_req(o_max_req), .o_block_max(o_block_max), .i_max_code_valid(i_max_code_valid),
	.i_max_code(i_max_code), .o_enc_valid(o_enc_valid), .o_enc_par(o_enc_par),
	.o_dec_ready(o_dec_ready), .o_out_valid(o_out_valid), .o_out_sample(o_out_sample));
